// File: logic/epu_cmd.sv
`timescale 1ns/100ps
`include "epu_params.svh"
// Summary of operation
// - Activation runs chosen sequence, busy throughout
// - Update option byte resets to ff
// - 91/99: clock on, load table, clock off
// - B1/B9: also fetch temperature before table
// - 47/4F: analog, drive, analog off, timebase off
// - 80 sets clock; C0 clock then analog
// - 44/4C: clock on, analog on, drive, flags stay
// - 04/0C: drive only, flags untouched
// - 03 clears analog then clock; 01 clock
// - 24 writes data bytes to mono memory
// - 26 writes data bytes to red memory
// - Pointers advance on each memory byte
// - 27 makes data reads return memory
// - Read source chosen by memory select
// - First read byte is dummy, host discards
// - 28 enters sensing, waits programmed duration
// - Sensed voltage latched at sensing end
// - Busy high during whole sensing operation
// - Sense wait is duration plus one seconds
// - Sense duration resets to 9

// ****************************************
// Three-stage input synchroniser
// ****************************************
module epu_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // Value changes once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Stages match q, so release makes no false edge
      s1 <= '1;
      s2 <= '1;
      s3 <= '1;
      q <= '1;
    end else if (ce) begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) q <= s3;
    end
  end
endmodule : epu_sync

// ****************************************
// Two-entry buffer
// ****************************************
module epu_fifo2 #(
  parameter int W = 9
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] slot0;
  logic [W-1:0] slot1;
  logic [1:0] cnt;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (cnt != 2'h2);
  assign out_valid = (cnt != 2'h0);
  assign out_data = slot0;

  // Slot zero is always the head
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slot0 <= '0;
      slot1 <= '0;
      cnt <= 2'h0;
    end else if (ce) begin
      if (pop) slot0 <= slot1;
      if (push && (cnt == 2'h0 || (cnt == 2'h1 && pop))) slot0 <= in_data;
      if (push && !(cnt == 2'h0 || (cnt == 2'h1 && pop))) slot1 <= in_data;
      cnt <= cnt + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : epu_fifo2

// ****************************************
// Command interpreter top
// ****************************************
module epu_cmd #(
  parameter int SENSE_UNIT_CYCLES = `EPU_SENSE_UNIT_MS * 1000000 / `EPU_CLK_PERIOD_NS
) (
  // Clock, reset, enable
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  // Serial link pins
  input wire logic CS_N,
  input wire logic SCL,
  input wire logic DC,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  // Pointer settings and read select
  input wire logic PTR_X_UP,
  input wire logic PTR_Y_UP,
  input wire logic RD_SEL_RED,
  // Step engine handshake
  output epu_pkg::epu_step_e STEP_OP,
  output logic STEP_MODE2,
  input wire logic STEP_DONE,
  // Sensing
  input wire logic [7:0] SENSE_VALUE,
  output logic [7:0] SENSED_VOLTAGE,
  // Status
  output epu_pkg::epu_flags_s FLAGS,
  output logic BUSY,
  output logic OVERRUN
);
  epu_pkg::epu_state_e state;
  epu_pkg::epu_state_e next_state;
  epu_pkg::epu_byte_s rx_byte;
  epu_pkg::epu_byte_s head;
  logic [3:0] pins;
  logic f_cs_n, f_scl, f_dc, f_sda, scl_q, cs_q;
  logic [7:0] sh_in, tx_sh, upd_opt, cur_cmd;
  logic [2:0] bit_cnt;
  logic [3:0] sense_dur, sec_cnt, x;
  logic [7:0] y;
  logic [24:0] tick;
  logic rd_mode, rd_first, tx_load;
  logic [7:0] mono_mem [0:`EPU_MEM_DEPTH-1];
  logic [7:0] red_mem [0:`EPU_MEM_DEPTH-1];
  logic [8:1] step_en;

  // ****************************************
  // Pin sampling and edge detection
  // ****************************************
  epu_sync #(.W(4)) u_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .ce(CE),
    .d({CS_N, SCL, DC, SDA_IN}),
    .q(pins)
  );
  assign {f_cs_n, f_scl, f_dc, f_sda} = pins;
  wire scl_rise = f_scl && !scl_q && !f_cs_n;
  wire scl_fall = !f_scl && scl_q && !f_cs_n;
  wire cs_fall = !f_cs_n && cs_q;
  wire byte_done = scl_rise && (bit_cnt == 3'h7);
  wire rd_phase = rd_mode && f_dc;
  wire [11:0] addr = {y, x};
  wire [7:0] mem_byte = RD_SEL_RED ? red_mem[addr] : mono_mem[addr];
  wire [7:0] rd_byte = rd_first ? `EPU_DUMMY_BYTE : mem_byte;
  wire rd_adv = byte_done && rd_phase && !rd_first;

  // ****************************************
  // Serial shifter
  // ****************************************
  // Shift in on rising, out on falling edges
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      scl_q <= 1'b1;
      cs_q <= 1'b1;
      sh_in <= 8'h00;
      bit_cnt <= 3'h0;
      tx_sh <= 8'h00;
      tx_load <= 1'b0;
    end else if (CE) begin
      scl_q <= f_scl;
      cs_q <= f_cs_n;
      tx_load <= byte_done && rd_phase;
      if (f_cs_n) bit_cnt <= 3'h0;
      else if (scl_rise) bit_cnt <= bit_cnt + 3'h1;
      if (scl_rise) sh_in <= {sh_in[6:0], f_sda};
      // Dummy byte stands ready until the host raises DC
      if (cs_fall || tx_load || (rd_first && !f_dc)) tx_sh <= rd_byte;
      else if (scl_fall && bit_cnt != 3'h0) tx_sh <= {tx_sh[6:0], 1'b0};
    end
  end

  assign SDA_OUT = tx_sh[7];
  assign SDA_OE_N = !(rd_phase && !f_cs_n);

  // ****************************************
  // Byte buffer toward the decoder
  // ****************************************
  logic rx_ready, head_valid;
  wire rx_push = byte_done && !rd_phase;
  wire pop = head_valid && (state == epu_pkg::ST_IDLE);
  assign rx_byte = '{dc: f_dc, data: {sh_in[6:0], f_sda}};

  epu_fifo2 #(.W(9)) u_fifo (
    .clk(CLK),
    .rst_n(RST_N),
    .ce(CE),
    .in_valid(rx_push),
    .in_ready(rx_ready),
    .in_data(rx_byte),
    .out_valid(head_valid),
    .out_ready(state == epu_pkg::ST_IDLE),
    .out_data(head)
  );

  // Sticky flag for a byte the full buffer refused
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) OVERRUN <= 1'b0;
    else if (CE && rx_push && !rx_ready) OVERRUN <= 1'b1;
  end

  // ****************************************
  // Command decode
  // ****************************************
  wire cmd_pop = pop && !head.dc;
  wire dat_pop = pop && head.dc;
  wire wr_mono = dat_pop && cur_cmd == `EPU_CMD_WR_MONO;
  wire wr_red = dat_pop && cur_cmd == `EPU_CMD_WR_RED;
  wire go_seq = cmd_pop && head.data == `EPU_CMD_ACTIVATE;
  wire go_sense = cmd_pop && head.data == `EPU_CMD_SENSE;

  // Command byte ends any earlier data phase
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cur_cmd <= 8'h00;
      upd_opt <= `EPU_UPD_OPT_RST;
      sense_dur <= `EPU_SENSE_DUR_RST;
      rd_mode <= 1'b0;
      rd_first <= 1'b0;
    end else if (CE) begin
      if (cmd_pop) begin
        cur_cmd <= head.data;
        rd_mode <= head.data == `EPU_CMD_RD_RAM;
        rd_first <= head.data == `EPU_CMD_RD_RAM;
      end else if (byte_done && rd_phase) begin
        rd_first <= 1'b0;
      end
      if (dat_pop && cur_cmd == `EPU_CMD_UPD_OPT) upd_opt <= head.data;
      if (dat_pop && cur_cmd == `EPU_CMD_SENSE_DUR) sense_dur <= head.data[3:0];
    end
  end

  // Frame memory writes
  always_ff @(posedge CLK) begin
    if (CE && wr_mono) mono_mem[addr] <= head.data;
    if (CE && wr_red) red_mem[addr] <= head.data;
  end

  // ****************************************
  // Address pointers
  // ****************************************
  wire adv = wr_mono || wr_red || rd_adv;
  wire x_wrap = PTR_X_UP ? (x == `EPU_XLAST) : (x == 4'h0);

  // X moves first and carries into Y
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      x <= 4'h0;
      y <= 8'h00;
    end else if (CE && adv) begin
      x <= PTR_X_UP ? x + 4'h1 : x - 4'h1;
      if (x_wrap && PTR_Y_UP) y <= (y == `EPU_YLAST) ? 8'h00 : y + 8'h01;
      if (x_wrap && !PTR_Y_UP) y <= (y == 8'h00) ? `EPU_YLAST : y - 8'h01;
    end
  end

  // ****************************************
  // Update sequence option decode
  // ****************************************
  wire o91 = upd_opt == 8'h91 || upd_opt == 8'h99;
  wire ob1 = upd_opt == 8'hb1 || upd_opt == 8'hb9;
  wire o47 = upd_opt == 8'h47 || upd_opt == 8'h4f;
  wire o44 = upd_opt == 8'h44 || upd_opt == 8'h4c;
  wire o04 = upd_opt == 8'h04 || upd_opt == 8'h0c;
  wire o80 = upd_opt == 8'h80;
  wire oc0 = upd_opt == 8'hc0;
  wire o03 = upd_opt == 8'h03;
  wire o01 = upd_opt == 8'h01;
  // Step enables, indexed by state code
  assign step_en[1] = o91 || ob1 || o80 || oc0 || o44;
  assign step_en[2] = o47 || o44 || oc0;
  assign step_en[3] = ob1;
  assign step_en[4] = o91 || ob1;
  assign step_en[5] = o47 || o44 || o04;
  assign step_en[6] = o47 || o03;
  assign step_en[7] = o91 || ob1 || o03 || o01;
  assign step_en[8] = o47;

  // First enabled step after the given one
  function automatic epu_pkg::epu_state_e step_after(input logic [3:0] cur, input logic [8:1] en);
    epu_pkg::epu_state_e r;
    r = epu_pkg::ST_IDLE;
    for (int i = 8; i >= 1; i--) begin
      if (en[i] && i > int'(cur)) r = epu_pkg::epu_state_e'(4'(i));
    end
    return r;
  endfunction : step_after

  wire waiting = state == epu_pkg::ST_TEMP || state == epu_pkg::ST_LUT || state == epu_pkg::ST_DRIVE;
  wire sense_end = state == epu_pkg::ST_SENSE && sec_cnt == sense_dur
    && tick == 25'(SENSE_UNIT_CYCLES - 1);

  // Next state of the sequencer
  always_comb begin
    case (state)
      epu_pkg::ST_IDLE: begin
        if (go_sense) next_state = epu_pkg::ST_SENSE;
        else if (go_seq) next_state = step_after(4'h0, step_en);
        else next_state = epu_pkg::ST_IDLE;
      end
      epu_pkg::ST_SENSE: next_state = sense_end ? epu_pkg::ST_IDLE : epu_pkg::ST_SENSE;
      default: begin
        if (waiting && !STEP_DONE) next_state = state;
        else next_state = step_after(state, step_en);
      end
    endcase
  end

  // ****************************************
  // Sequencer, flags and sensing timer
  // ****************************************
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) state <= epu_pkg::ST_IDLE;
    else if (CE) state <= next_state;
  end

  // Flag changes made by the single-cycle steps
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      FLAGS <= '{clock_enable_flag: 1'b0, analog_enable_flag: 1'b0, internal_timebase: 1'b1};
    end else if (CE) begin
      case (state)
        epu_pkg::ST_CLK_ON: begin
          FLAGS.clock_enable_flag <= 1'b1;
          FLAGS.internal_timebase <= 1'b1;
        end
        epu_pkg::ST_ANA_ON: FLAGS.analog_enable_flag <= 1'b1;
        epu_pkg::ST_ANA_OFF: FLAGS.analog_enable_flag <= 1'b0;
        epu_pkg::ST_CLK_OFF: FLAGS.clock_enable_flag <= 1'b0;
        epu_pkg::ST_TB_OFF: begin
          FLAGS.clock_enable_flag <= 1'b0;
          FLAGS.internal_timebase <= 1'b0;
        end
        default: FLAGS <= FLAGS;
      endcase
    end
  end

  // Seconds timer for sensing, result latched at the end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tick <= 25'h0000000;
      sec_cnt <= 4'h0;
      SENSED_VOLTAGE <= 8'h00;
    end else if (CE) begin
      if (state != epu_pkg::ST_SENSE) begin
        tick <= 25'h0000000;
        sec_cnt <= 4'h0;
      end else if (tick == 25'(SENSE_UNIT_CYCLES - 1)) begin
        tick <= 25'h0000000;
        sec_cnt <= sec_cnt + 4'h1;
      end else begin
        tick <= tick + 25'h0000001;
      end
      if (sense_end) SENSED_VOLTAGE <= SENSE_VALUE;
    end
  end

  assign BUSY = state != epu_pkg::ST_IDLE;
  assign STEP_OP = state == epu_pkg::ST_TEMP ? epu_pkg::STEP_TEMP :
    state == epu_pkg::ST_LUT ? epu_pkg::STEP_LUT :
    state == epu_pkg::ST_DRIVE ? epu_pkg::STEP_DRIVE : epu_pkg::STEP_NONE;
  assign STEP_MODE2 = upd_opt[3];

  // ****************************************
  // Checks
  // ****************************************
  sequence lut_then_off;
    state == epu_pkg::ST_LUT && STEP_DONE && CE ##1 state == epu_pkg::ST_CLK_OFF;
  endsequence

  act_busy_a: assert property (@(posedge CLK) disable iff (!RST_N)
    go_seq && CE && step_en != 8'h00 |=> BUSY)
    else $error("busy missing after activation");
  opt_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
    !(dat_pop && cur_cmd == `EPU_CMD_UPD_OPT) |=> $stable(upd_opt))
    else $error("option byte changed unasked");
  lut_clock_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (o91 ##1 o91) and lut_then_off |=> !FLAGS.clock_enable_flag)
    else $error("clock left on after table load");
  temp_lut_a: assert property (@(posedge CLK) disable iff (!RST_N)
    state == epu_pkg::ST_TEMP && STEP_DONE && CE |=> state == epu_pkg::ST_LUT && FLAGS.clock_enable_flag)
    else $error("table load not after temperature");
  tb_off_a: assert property (@(posedge CLK) disable iff (!RST_N)
    state == epu_pkg::ST_TB_OFF && CE |=> !FLAGS.internal_timebase && state == epu_pkg::ST_IDLE)
    else $error("timebase not stopped");
  drive_only_a: assert property (@(posedge CLK) disable iff (!RST_N)
    o04 && state == epu_pkg::ST_DRIVE |=> $stable(FLAGS))
    else $error("drive-only option touched flags");
  mono_write_a: assert property (@(posedge CLK) disable iff (!RST_N)
    wr_mono && CE |=> mono_mem[$past(addr)] == $past(head.data))
    else $error("mono memory byte not stored");
  ptr_step_a: assert property (@(posedge CLK) disable iff (!RST_N)
    adv && CE && !x_wrap |=> x != $past(x) && y == $past(y))
    else $error("pointer did not advance");
  sense_busy_a: assert property (@(posedge CLK) disable iff (!RST_N)
    go_sense && CE |=> BUSY [*8])
    else $error("busy dropped during sensing");
  sense_latch_a: assert property (@(posedge CLK) disable iff (!RST_N)
    sense_end && CE |=> SENSED_VOLTAGE == $past(SENSE_VALUE) && !BUSY)
    else $error("sensed voltage not latched");
endmodule : epu_cmd

// File: logic/epu_params.svh
`ifndef EPU_PARAMS_SVH
`define EPU_PARAMS_SVH
// ****************************************
// Command codes
// ****************************************
`define EPU_CMD_ACTIVATE 8'h20
`define EPU_CMD_UPD_OPT 8'h22
`define EPU_CMD_WR_MONO 8'h24
`define EPU_CMD_WR_RED 8'h26
`define EPU_CMD_RD_RAM 8'h27
`define EPU_CMD_SENSE 8'h28
`define EPU_CMD_SENSE_DUR 8'h29
// ****************************************
// Reset values and dummy read byte
// ****************************************
`define EPU_UPD_OPT_RST 8'hff
`define EPU_SENSE_DUR_RST 4'h9
`define EPU_DUMMY_BYTE 8'h00
// ****************************************
// Frame memory geometry
// ****************************************
`define EPU_XBYTES 16
`define EPU_XLAST 4'hf
`define EPU_YLAST 8'hf9
`define EPU_MEM_DEPTH 4000
// ****************************************
// Timing
// ****************************************
`define EPU_CLK_PERIOD_NS 50
`define EPU_SENSE_UNIT_MS 1000
`endif

// File: logic/epu_pkg.sv
package epu_pkg;
  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_CLK_ON = 4'h1,
    ST_ANA_ON = 4'h2,
    ST_TEMP = 4'h3,
    ST_LUT = 4'h4,
    ST_DRIVE = 4'h5,
    ST_ANA_OFF = 4'h6,
    ST_CLK_OFF = 4'h7,
    ST_TB_OFF = 4'h8,
    ST_SENSE = 4'h9
  } epu_state_e;

  // Long steps handed to the step engine
  typedef enum logic [1:0] {
    STEP_NONE = 2'h0,
    STEP_TEMP = 2'h1,
    STEP_LUT = 2'h2,
    STEP_DRIVE = 2'h3
  } epu_step_e;

  // A received byte with its command/data marker
  typedef struct packed {
    logic dc;
    logic [7:0] data;
  } epu_byte_s;

  // Enable flags
  typedef struct packed {
    logic clock_enable_flag;
    logic analog_enable_flag;
    logic internal_timebase;
  } epu_flags_s;
endpackage : epu_pkg

// File: verification/epu_host_model.sv
`timescale 1ns/100ps
// ****************************************
// Host side of the serial command link
// ****************************************
module epu_host_model (
  // Clock
  input wire logic clk,
  // Serial link pins
  output logic cs_n,
  output logic scl,
  output logic dc,
  output logic sda_in,
  input wire logic sda_out
);
  // Idle link: deselected, clock parked low
  initial begin
    cs_n = 1'b1;
    scl = 1'b0;
    dc = 1'b0;
    sda_in = 1'b0;
  end

  // Select and let the selection pass the synchroniser
  task automatic frame_open;
    cs_n = 1'b0;
    repeat (4) @(negedge clk);
  endtask : frame_open

  // Deselect; released data line shows the inverse of its last bit
  task automatic frame_close;
    repeat (2) @(negedge clk);
    cs_n = 1'b1;
    sda_in = ~sda_in;
    repeat (6) @(negedge clk);
  endtask : frame_close

  // One byte MSB first, 8 CLK a bit; read bit taken mid high phase
  task automatic xfer(input logic d, input logic [7:0] w, output logic [7:0] r);
    dc = d;
    for (int i = 7; i >= 0; i--) begin
      sda_in = w[i];
      repeat (4) @(negedge clk);
      scl = 1'b1;
      repeat (2) @(negedge clk);
      r[i] = sda_out;
      repeat (2) @(negedge clk);
      scl = 1'b0;
    end
    repeat (4) @(negedge clk);
  endtask : xfer
endmodule : epu_host_model

// File: verification/tb_top.sv
`timescale 1ns/100ps
`include "epu_params.svh"
module tb_top;
  localparam int UNIT = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic x_up = 1'b1;
  logic sel_red = 1'b0;
  logic step_done = 1'b0;
  logic [7:0] sense_val = 8'h00;
  logic cs_n, scl, dc, sda_in, sda_out, sda_oe_n, step_mode2, busy, overrun, m2;
  logic [7:0] sensed;
  epu_pkg::epu_step_e step_op;
  epu_pkg::epu_flags_s flags;
  int n_fail = 0;
  int num_checks = 0;
  int bcnt = 0;
  int blen = 0;
  int nseq = 0;
  int dly = 0;
  logic [5:0] trace = 6'h00;
  logic [7:0] mem [2][4];
  logic [7:0] codes [15] = '{8'h80, 8'hc0, 8'h01, 8'h03, 8'h04, 8'h0c, 8'h91, 8'hb1, 8'h99, 8'hb9,
    8'h44, 8'h4c, 8'h47, 8'h4f, 8'h90};

  // 20 MHz clock
  always #25 clk = ~clk;

  epu_cmd #(.SENSE_UNIT_CYCLES(UNIT)) u_dut (.CLK(clk), .RST_N(rst_n), .CE(1'b1), .CS_N(cs_n), .SCL(scl),
    .DC(dc), .SDA_IN(sda_in), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .PTR_X_UP(x_up), .PTR_Y_UP(1'b1),
    .RD_SEL_RED(sel_red), .STEP_OP(step_op), .STEP_MODE2(step_mode2), .STEP_DONE(step_done),
    .SENSE_VALUE(sense_val), .SENSED_VOLTAGE(sensed), .FLAGS(flags), .BUSY(busy), .OVERRUN(overrun));
  epu_host_model u_host (.clk(clk), .cs_n(cs_n), .scl(scl), .dc(dc), .sda_in(sda_in), .sda_out(sda_out));

  // ****************************************
  // Step engine and busy monitor
  // ****************************************
  // Step engine answers after 0 to 3 cycles
  always @(negedge clk) begin
    if (step_done) begin
      step_done <= 1'b0;
      dly <= $urandom_range(3, 0);
    end else if (step_op !== epu_pkg::STEP_NONE) begin
      if (dly == 0) step_done <= 1'b1;
      else dly <= dly - 1;
    end
  end

  // Busy run length, sequence count and finished steps
  always @(posedge clk) begin
    if (busy === 1'b1) begin
      if (bcnt == 0) trace <= 6'h00;
      bcnt <= bcnt + 1;
    end else if (bcnt != 0) begin
      blen <= bcnt;
      bcnt <= 0;
      nseq <= nseq + 1;
    end
    if (step_done && step_op !== epu_pkg::STEP_NONE) begin
      trace <= {trace[3:0], step_op};
      m2 <= step_mode2;
    end
  end

  // ****************************************
  // Expectations and shared tasks
  // ****************************************
  function automatic logic [5:0] exp_steps(input logic [7:0] c);
    case (c)
      8'h91, 8'h99: return {4'h0, epu_pkg::STEP_LUT};
      8'hb1, 8'hb9: return {2'h0, epu_pkg::STEP_TEMP, epu_pkg::STEP_LUT};
      8'h47, 8'h4f, 8'h44, 8'h4c, 8'h04, 8'h0c: return {4'h0, epu_pkg::STEP_DRIVE};
      default: return 6'h00;
    endcase
  endfunction : exp_steps

  // Flags {clock, analog, timebase} after a sequence
  function automatic logic [2:0] exp_flags(input logic [7:0] c, input logic [2:0] f);
    case (c)
      8'h80: f = f | 3'b101;
      8'hc0: f = 3'b111;
      8'h91, 8'h99, 8'hb1, 8'hb9: f = {1'b0, f[1], 1'b1};
      8'h47, 8'h4f: f = 3'b000;
      8'h44, 8'h4c: f = f | 3'b110;
      8'h03: f = f & 3'b001;
      8'h01: f = f & 3'b011;
      default: f = f;
    endcase
    return f;
  endfunction : exp_flags

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run

  // Bounded wait for the next busy run to end
  task automatic wait_seq(input int n0);
    for (int i = 0; i < 1500 && nseq == n0; i++) @(negedge clk);
  endtask : wait_seq

  task automatic do_opt(input logic [7:0] c, input logic wr);
    logic [2:0] ef;
    logic [7:0] r;
    int n0;
    logic ok;
    ef = exp_flags(c, flags);
    ok = c inside {8'h80, 8'hc0, 8'h01, 8'h03, 8'h04, 8'h0c, 8'h91, 8'hb1, 8'h99, 8'hb9, 8'h44, 8'h4c,
      8'h47, 8'h4f};
    n0 = nseq;
    u_host.frame_open;
    if (wr) u_host.xfer(1'b0, `EPU_CMD_UPD_OPT, r);
    if (wr) u_host.xfer(1'b1, c, r);
    u_host.xfer(1'b0, `EPU_CMD_ACTIVATE, r);
    u_host.frame_close;
    wait_seq(n0);
    chk("sequence ran", ok, nseq != n0);
    chk("steps", exp_steps(c), (nseq != n0) ? trace : 6'h00);
    chk("flags", ef, flags);
    if (exp_steps(c) != 6'h00) chk("mode2", c[3], m2);
  endtask : do_opt

  task automatic sense(input int d, input logic ovr);
    logic [7:0] r;
    int n0;
    sense_val = 8'($urandom);
    n0 = nseq;
    u_host.frame_open;
    u_host.xfer(1'b0, `EPU_CMD_SENSE, r);
    if (ovr) begin
      u_host.xfer(1'b0, `EPU_CMD_SENSE_DUR, r);
      u_host.xfer(1'b1, 8'h45, r);
      chk("overrun two", 1'b0, overrun);
      u_host.xfer(1'b0, `EPU_CMD_SENSE_DUR, r);
      chk("overrun three", 1'b1, overrun);
    end
    u_host.frame_close;
    wait_seq(n0);
    chk("sense length", 1'b1, blen >= (d + 1) * UNIT && blen <= (d + 1) * UNIT + 1);
    chk("sensed", sense_val, sensed);
  endtask : sense

  // Four random bytes; white or red pixels are 1
  task automatic wr_mem(input logic red, input logic up);
    logic [7:0] r;
    x_up = up;
    u_host.frame_open;
    u_host.xfer(1'b0, red ? `EPU_CMD_WR_RED : `EPU_CMD_WR_MONO, r);
    for (int i = 0; i < 4; i++) begin
      mem[red][i] = 8'($urandom);
      u_host.xfer(1'b1, mem[red][i], r);
    end
    u_host.frame_close;
  endtask : wr_mem

  task automatic rd_mem(input logic red, input logic up);
    logic [7:0] r;
    x_up = up;
    sel_red = red;
    u_host.frame_open;
    u_host.xfer(1'b0, `EPU_CMD_RD_RAM, r);
    u_host.xfer(1'b1, 8'h00, r);
    chk("dummy byte", `EPU_DUMMY_BYTE, r);
    for (int i = 0; i < 4; i++) begin
      u_host.xfer(1'b1, 8'h00, r);
      chk("read byte", mem[red][i], r);
    end
    chk("oe reading", 1'b0, sda_oe_n);
    u_host.frame_close;
    chk("oe idle", 1'b1, sda_oe_n);
  endtask : rd_mem

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    logic [7:0] r;
    int d;
    void'($urandom(15415));
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk("flags at reset", 3'b001, flags);
    chk("busy at reset", 1'b0, busy);
    chk("oe at reset", 1'b1, sda_oe_n);
    do_opt(8'hff, 1'b0);
    foreach (codes[i]) do_opt(codes[i], 1'b1);
    do_opt(8'hc0, 1'b1);
    sense(9, 1'b0);
    for (int k = 0; k < 3; k++) begin
      d = (k == 0) ? 0 : (k == 1) ? $urandom_range(14, 1) : 15;
      u_host.frame_open;
      u_host.xfer(1'b0, `EPU_CMD_SENSE_DUR, r);
      u_host.xfer(1'b1, {4'h4, 4'(d)}, r);
      u_host.frame_close;
      sense(d, 1'b0);
    end
    sense(15, 1'b1);
    sense(5, 1'b0);
    wr_mem(1'b0, 1'b1);
    wr_mem(1'b1, 1'b0);
    rd_mem(1'b0, 1'b1);
    rd_mem(1'b1, 1'b0);
    complete_run;
  end

  // Run needs about 10000 cycles; 40000 cut a hang
  initial begin
    #2000000;
    n_fail++;
    complete_run;
  end
endmodule : tb_top
